//--- hdl/spiee_top.v
// Serial EEPROM slave: SPI command decode, status and protection,
// sequential read through a prefetch FIFO, page-buffered writes.
// Assumes SPI pins arrive asynchronous to ref_clk and the serial
// clock is well below a quarter of ref_clk.
`timescale 1ns/1ps
`include "spiee_map.vh"

module spiee_fifo #(
  parameter W  = 8,
  parameter D  = 8,
  parameter AW = 3
) (
  // Clock and reset
  input  wire          ref_clk,
  input  wire          rst_b,
  input  wire          flush,
  // Fill side
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  // Drain side
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg  [W-1:0] mem_q [0:D-1];
  reg  [AW-1:0] wr_q;
  reg  [AW-1:0] rd_q;
  reg  [AW:0]   cnt_q;
  wire          push;
  wire          pop;

  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  always @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // spiee_fifo

// Notes on behaviour
// - 06h sets latch, 04h clears it
// - 03h array read, 02h array write
// - 05h status read, 01h status write
// - Status: lock, zeros, guards, latch, busy
// - After latch opcodes, wait for deselect
// - Status readable anytime, busy shows writing
// - Status write needs latch, clears latch
// - Lock and guards frozen while busy
// - Status write only on deselect at sixteen
// - Guard codes: none, quarter, half, all
// - Same range in both guard modes
// - Protected array bytes dropped despite latch
// - Pin mode when lock set, pin low
// - Lock written with or apart from guards
// - Pin mode blocks status write, pin releases
// - Two address bytes, top bit ignored
// - Output on falling edge, address increments
// - Read address wraps to zero
// - Deselect ends read, output released
// - Read during busy rejected, self-deselect
// - Byte write: opcode, address, data
// - Write cancelled unless deselect on boundary
// - Valid deselect starts timed write cycle
// - Unknown opcode deselects the device
// - Input MSB first on rising edges
// - Write address wraps within page
// - Latch clears at reset and completions
module spiee_top #(
  parameter [15:0] PROG_CYCLES = `SPIEE_PROG_CYCLES
) (
  // Clock and reset
  input  wire ref_clk,
  input  wire rst_b,
  // Serial link
  input  wire spi_clk,
  input  wire spi_cs_b,
  input  wire spi_din,
  output reg  spi_dout_q,
  output reg  spi_dout_oe_q,
  // Write guard
  input  wire wp_b,
  output reg  pin_guard_mode_q
);
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_OPC  = 8'h02;
  localparam [7:0] ST_ADDR = 8'h04;
  localparam [7:0] ST_RDAT = 8'h08;
  localparam [7:0] ST_SRRD = 8'h10;
  localparam [7:0] ST_SRWR = 8'h20;
  localparam [7:0] ST_WDAT = 8'h40;
  localparam [7:0] ST_WAIT = 8'h80;

  // Pin synchronisers
  reg clk_s1_q, clk_s2_q, clk_s3_q;
  reg cs_s1_q, cs_s2_q, cs_s3_q;
  reg din_s1_q, din_s2_q;
  reg wp_s1_q, wp_s2_q;

  // Command engine
  reg [7:0]            state_q;
  reg [2:0]            bit_q;
  reg [2:0]            byte_q;
  reg [6:0]            shift_q;
  reg                  is_rd_q;
  reg [`SPIEE_AW-1:0]  addr_q;
  reg [`SPIEE_PG_W-1:0] wr_off_q;
  reg                  got_data_q;
  reg [`SPIEE_PG_BYTES-1:0] mask_q;
  reg [7:0]            pend_q;

  // Status and programming
  reg                  lock_q, ghi_q, glo_q;
  reg                  latch_q;
  reg                  busy_q;
  reg [15:0]           prog_cnt_q;
  reg                  arr_kind_q;
  reg                  prog_start_q;
  reg [`SPIEE_PG_W:0]  cm_idx_q;
  reg                  cm_on_q;

  // Read prefetch
  reg                  fill_en_q;
  reg                  fill_v_q;
  reg [7:0]            fill_byte_q;
  reg [`SPIEE_AW-1:0]  fill_addr_q;
  reg [6:0]            out_sh_q;
  reg [2:0]            out_bit_q;

  reg [7:0] mem_q [0:`SPIEE_WORDS-1];
  reg [7:0] pbuf_q [0:`SPIEE_PG_BYTES-1];

  wire       sclk_rise = clk_s2_q & ~clk_s3_q;
  wire       sclk_fall = ~clk_s2_q & clk_s3_q;
  wire       cs_rise   = cs_s2_q & ~cs_s3_q;
  wire       sel       = ~cs_s2_q;
  wire       shifting  = ~state_q[0] & ~state_q[7];
  wire       byte_done = sclk_rise & shifting & (bit_q == 3'h7);
  wire [7:0] byte_v    = {shift_q, din_s2_q};
  wire [`SPIEE_AW-1:0] wr_addr = {addr_q[`SPIEE_AW-1:`SPIEE_PG_W],
                                  wr_off_q};
  wire [7:0] status_v  = {lock_q, 3'h0, ghi_q, glo_q, latch_q, busy_q};
  wire       wr_prot   = prot(ghi_q, glo_q, wr_addr);
  wire       buf_we    = byte_done & state_q[6] & ~wr_prot;
  wire       cm_we     = cm_on_q & mask_q[cm_idx_q[`SPIEE_PG_W-1:0]];
  wire       fifo_in_rdy;
  wire       fifo_out_v;
  wire [7:0] fifo_out;
  wire       fifo_pop  = sclk_fall & state_q[3] & (out_bit_q == 3'h0);
  // Last address bit of a read: prefetch must beat the next fall
  wire       fill_go   = byte_done & state_q[2] & is_rd_q &
                         (byte_q == `SPIEE_BYTE_ADDR_LO);
  wire [`SPIEE_AW-1:0] fill_start = {addr_q[`SPIEE_AW-1:8], byte_v};

  function prot;
    input                 g_hi;
    input                 g_lo;
    input [`SPIEE_AW-1:0] a;
    begin
      case ({g_hi, g_lo})
        2'h0:    prot = 1'b0;
        2'h1:    prot = a[14] & a[13];
        2'h2:    prot = a[14];
        default: prot = 1'b1;
      endcase
    end
  endfunction

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
    end else begin
      clk_s1_q <= spi_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      cs_s1_q  <= spi_cs_b;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      din_s1_q <= spi_din;
      din_s2_q <= din_s1_q;
      wp_s1_q  <= wp_b;
      wp_s2_q  <= wp_s1_q;
    end
  end

  // Guard pin is level sensitive, so leaving pin mode needs no event
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_guard_mode_q <= 1'b0;
    end else begin
      pin_guard_mode_q <= lock_q & ~wp_s2_q;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q      <= ST_IDLE;
      bit_q        <= 3'h0;
      byte_q       <= 3'h0;
      shift_q      <= 7'h00;
      is_rd_q      <= 1'b0;
      addr_q       <= {`SPIEE_AW{1'b0}};
      wr_off_q     <= {`SPIEE_PG_W{1'b0}};
      got_data_q   <= 1'b0;
      mask_q       <= {`SPIEE_PG_BYTES{1'b0}};
      pend_q       <= `SPIEE_SR_RESET;
      lock_q       <= 1'b0;
      ghi_q        <= 1'b0;
      glo_q        <= 1'b0;
      latch_q      <= 1'b0;
      busy_q       <= 1'b0;
      prog_cnt_q   <= 16'h0000;
      arr_kind_q   <= 1'b0;
      prog_start_q <= 1'b0;
    end else begin
      prog_start_q <= 1'b0;
      if (busy_q) begin
        prog_cnt_q <= prog_cnt_q - 16'h0001;
        if (prog_cnt_q == 16'h0001) begin
          busy_q <= 1'b0;
          latch_q <= 1'b0;
          if (!arr_kind_q) begin
            lock_q <= pend_q[`SPIEE_SR_LOCK];
            ghi_q  <= pend_q[`SPIEE_SR_GHI];
            glo_q  <= pend_q[`SPIEE_SR_GLO];
          end
        end
      end
      if (cs_rise) begin
        state_q <= ST_IDLE;
        if (state_q == ST_WDAT && bit_q == 3'h0 && got_data_q &&
            latch_q && !busy_q) begin
          busy_q       <= 1'b1;
          prog_cnt_q   <= PROG_CYCLES;
          arr_kind_q   <= 1'b1;
          prog_start_q <= 1'b1;
        end else if (state_q == ST_SRWR &&
                     byte_q == `SPIEE_BYTE_ADDR_LO &&
                     bit_q == 3'h0 && latch_q &&
                     !pin_guard_mode_q && !busy_q) begin
          busy_q       <= 1'b1;
          prog_cnt_q   <= PROG_CYCLES;
          arr_kind_q   <= 1'b0;
          prog_start_q <= 1'b1;
        end
      end else if (sel && state_q == ST_IDLE) begin
        state_q <= ST_OPC;
        bit_q   <= 3'h0;
        byte_q  <= 3'h0;
      end else if (sclk_rise && shifting) begin
        shift_q <= byte_v[6:0];
        bit_q   <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          if (byte_q != `SPIEE_BYTE_SAT) begin
            byte_q <= byte_q + 3'h1;
          end
          case (state_q)
            ST_OPC: begin
              case (byte_v)
                `SPIEE_OP_LATCH_SET: begin
                  latch_q <= 1'b1;
                  state_q <= ST_WAIT;
                end
                `SPIEE_OP_LATCH_CLEAR: begin
                  latch_q <= 1'b0;
                  state_q <= ST_WAIT;
                end
                `SPIEE_OP_STATUS_READ:  state_q <= ST_SRRD;
                `SPIEE_OP_STATUS_WRITE: state_q <= ST_SRWR;
                `SPIEE_OP_ARRAY_READ: begin
                  is_rd_q <= 1'b1;
                  state_q <= busy_q ? ST_WAIT : ST_ADDR;
                end
                `SPIEE_OP_ARRAY_WRITE: begin
                  is_rd_q <= 1'b0;
                  state_q <= busy_q ? ST_WAIT : ST_ADDR;
                end
                default: state_q <= ST_WAIT;
              endcase
            end
            ST_ADDR: begin
              if (byte_q == `SPIEE_BYTE_ADDR_HI) begin
                addr_q[14:8] <= byte_v[6:0];
              end else begin
                addr_q[7:0] <= byte_v;
                wr_off_q    <= byte_v[`SPIEE_PG_W-1:0];
                if (is_rd_q) begin
                  state_q   <= ST_RDAT;
                end else begin
                  state_q    <= ST_WDAT;
                  got_data_q <= 1'b0;
                  mask_q     <= {`SPIEE_PG_BYTES{1'b0}};
                end
              end
            end
            ST_SRWR: begin
              // Pending value must not change under a running cycle
              if (!busy_q) begin
                pend_q <= byte_v;
              end
            end
            ST_WDAT: begin
              got_data_q <= 1'b1;
              if (!wr_prot) begin
                mask_q[wr_off_q] <= 1'b1;
              end
              wr_off_q <= wr_off_q + 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always @(posedge ref_clk) begin
    if (buf_we) begin
      pbuf_q[wr_off_q] <= byte_v;
    end
  end

  // Page commit runs during busy cycles 2 through 65
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cm_idx_q <= {(`SPIEE_PG_W+1){1'b0}};
      cm_on_q  <= 1'b0;
    end else if (prog_start_q && arr_kind_q) begin
      cm_idx_q <= {(`SPIEE_PG_W+1){1'b0}};
      cm_on_q  <= 1'b1;
    end else if (cm_on_q) begin
      cm_idx_q <= cm_idx_q + 1'b1;
      if (cm_idx_q[`SPIEE_PG_W-1:0] == `SPIEE_PG_LAST) begin
        cm_on_q <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (cm_we) begin
      mem_q[{addr_q[`SPIEE_AW-1:`SPIEE_PG_W],
             cm_idx_q[`SPIEE_PG_W-1:0]}] <=
        pbuf_q[cm_idx_q[`SPIEE_PG_W-1:0]];
    end
  end

  // Prefetch runs ahead of the shifter; the FIFO absorbs the lead
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_en_q   <= 1'b0;
      fill_v_q    <= 1'b0;
      fill_byte_q <= 8'h00;
      fill_addr_q <= {`SPIEE_AW{1'b0}};
    end else if (cs_rise) begin
      fill_en_q <= 1'b0;
      fill_v_q  <= 1'b0;
    end else if (fill_go) begin
      fill_en_q   <= 1'b1;
      fill_v_q    <= 1'b1;
      fill_byte_q <= mem_q[fill_start];
      fill_addr_q <= fill_start + 1'b1;
    end else if (fill_en_q && (!fill_v_q || fifo_in_rdy)) begin
      fill_v_q    <= 1'b1;
      fill_byte_q <= mem_q[fill_addr_q];
      fill_addr_q <= fill_addr_q + 1'b1;
    end else if (fifo_in_rdy) begin
      fill_v_q <= 1'b0;
    end
  end

  spiee_fifo #(
    .W  (`SPIEE_FIFO_W),
    .D  (`SPIEE_FIFO_D),
    .AW (`SPIEE_FIFO_AW)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .flush     (cs_rise),
    .in_valid  (fill_v_q),
    .in_ready  (fifo_in_rdy),
    .in_data   (fill_byte_q),
    .out_valid (fifo_out_v),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      spi_dout_q    <= 1'b0;
      spi_dout_oe_q <= 1'b0;
      out_sh_q      <= 7'h00;
      out_bit_q     <= 3'h0;
    end else if (cs_rise || !(state_q[3] || state_q[4])) begin
      spi_dout_q    <= 1'b0;
      spi_dout_oe_q <= 1'b0;
      out_bit_q     <= 3'h0;
    end else if (sclk_fall) begin
      spi_dout_oe_q <= 1'b1;
      out_bit_q     <= out_bit_q + 3'h1;
      if (out_bit_q == 3'h0) begin
        if (state_q[4]) begin
          spi_dout_q <= status_v[7];
          out_sh_q   <= status_v[6:0];
        end else begin
          spi_dout_q <= fifo_out_v & fifo_out[7];
          out_sh_q   <= fifo_out_v ? fifo_out[6:0] : 7'h00;
        end
      end else begin
        spi_dout_q <= out_sh_q[6];
        out_sh_q   <= {out_sh_q[5:0], 1'b0};
      end
    end
  end
endmodule // spiee_top

//--- hdl/spiee_map.vh
// Constants for the serial EEPROM command and protection block.
// Assumes inclusion by bare name from the design file.
`ifndef SPIEE_MAP_VH
`define SPIEE_MAP_VH

// Opcodes
`define SPIEE_OP_LATCH_SET    8'h06
`define SPIEE_OP_LATCH_CLEAR  8'h04
`define SPIEE_OP_STATUS_READ  8'h05
`define SPIEE_OP_STATUS_WRITE 8'h01
`define SPIEE_OP_ARRAY_READ   8'h03
`define SPIEE_OP_ARRAY_WRITE  8'h02

// Status register fields
`define SPIEE_SR_LOCK   7
`define SPIEE_SR_GHI    3
`define SPIEE_SR_GLO    2
`define SPIEE_SR_LATCH  1
`define SPIEE_SR_BUSY   0
`define SPIEE_SR_RESET  8'h00

// Array geometry, larger variant
`define SPIEE_AW        15
`define SPIEE_WORDS     32768
`define SPIEE_PG_W      6
`define SPIEE_PG_BYTES  64
`define SPIEE_PG_LAST   6'h3F

// Frame byte positions
`define SPIEE_BYTE_ADDR_HI 3'h1
`define SPIEE_BYTE_ADDR_LO 3'h2
`define SPIEE_BYTE_SAT     3'h4

// Read prefetch FIFO
`define SPIEE_FIFO_W    8
`define SPIEE_FIFO_D    8
`define SPIEE_FIFO_AW   3

// Self-timed programming length, ref_clk cycles (at least 64)
`define SPIEE_PROG_CYCLES 16'h03E8

`endif

//--- sim/spiee_props.sv
// Checker for the serial EEPROM block, top ports only.
// Assumes a serial clock of 8 ref_clk cycles per period or slower.
`timescale 1ns/1ps
module spiee_props #(
  parameter [15:0] PROG_CYCLES = 16'h03E8
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Serial link
  input wire spi_clk,
  input wire spi_cs_b,
  input wire spi_din,
  input wire spi_dout_q,
  input wire spi_dout_oe_q,
  // Write guard
  input wire wp_b,
  input wire pin_guard_mode_q
);
  logic [5:0] rise_cnt_q;
  logic       clk_seen_q;

  // Pin-level rises since select, saturating
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_cnt_q <= 6'h00;
      clk_seen_q <= 1'b0;
    end else begin
      clk_seen_q <= spi_clk;
      if (spi_cs_b)
        rise_cnt_q <= 6'h00;
      else if (spi_clk && !clk_seen_q && rise_cnt_q != 6'h3F)
        rise_cnt_q <= rise_cnt_q + 6'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_oe_start;
    $rose(spi_dout_oe_q) |-> rise_cnt_q inside {6'h08, 6'h09, 6'h18, 6'h19};
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("output enable rose at a wrong bit count");

  property p_oe_release;
    $rose(spi_cs_b) |-> ##[1:6] !spi_dout_oe_q;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("output still driven after deselect");

  property p_oe_idle;
    spi_cs_b [*8] |-> !spi_dout_oe_q;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");

  property p_dout_hold;
    $rose(spi_clk) |-> ##2 $stable(spi_dout_q) [*3];
  endproperty
  a_dout_hold: assert property (p_dout_hold)
    else $error("data out changed near a rising serial edge");

  property p_oe_fall;
    $rose(spi_dout_oe_q) |-> $past(spi_clk, 4) && !$past(spi_clk, 3);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("output enable not tied to a falling edge");

  property p_pg_on;
    pin_guard_mode_q |-> !$past(wp_b, 3) || !$past(wp_b, 4);
  endproperty
  a_pg_on: assert property (p_pg_on)
    else $error("pin guard mode without a low guard pin");

  property p_pg_exit;
    $fell(pin_guard_mode_q) |-> $past(wp_b, 3) || $past(wp_b, 4);
  endproperty
  a_pg_exit: assert property (p_pg_exit)
    else $error("pin guard mode left with the pin low");

  property p_pg_idle;
    wp_b [*6] |-> !pin_guard_mode_q;
  endproperty
  a_pg_idle: assert property (p_pg_idle)
    else $error("pin guard mode held with the pin high");
endmodule // spiee_props

bind spiee_top spiee_props #(.PROG_CYCLES(PROG_CYCLES)) i_spiee_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .spi_clk(spi_clk),
  .spi_cs_b(spi_cs_b), .spi_din(spi_din), .spi_dout_q(spi_dout_q),
  .spi_dout_oe_q(spi_dout_oe_q), .wp_b(wp_b),
  .pin_guard_mode_q(pin_guard_mode_q)
);

//--- sim/spiee_host.sv
// Host model: drives mode 0 frames at a 32 ns serial clock.
// Assumes the bench calls frame() and watches rx_stb for bytes.
`timescale 1ns/1ps
module spiee_host (
  // Serial link
  output reg       spi_clk,
  output reg       spi_cs_b,
  output reg       spi_din,
  input  wire      spi_dout,
  input  wire      spi_dout_oe,
  // Received bytes
  output reg       rx_stb,
  output reg [7:0] rx_b
);
  initial begin
    spi_clk  = 1'b0;
    spi_cs_b = 1'b1;
    spi_din  = 1'b0;
    rx_stb   = 1'b0;
    rx_b     = 8'h00;
  end

  task automatic frame(input logic [7:0] tx[$], input int nbits);
    int i;
    int k;
    begin
      k = 0;
      // Whole cycles keep every pin change off the rising ref_clk
      #4 spi_cs_b = 1'b0;
      for (i = 0; i < nbits; i++) begin
        spi_din = (i / 8 < tx.size()) ? tx[i/8][7-i%8] : 1'($urandom);
        #16 spi_clk = 1'b1;
        // Slow sampler: mid high phase
        #8 if (spi_dout_oe) begin
          rx_b = {rx_b[6:0], spi_dout};
          k++;
          if (k % 8 == 0) rx_stb = ~rx_stb;
        end
        #8 spi_clk = 1'b0;
      end
      #16 spi_cs_b = 1'b1;
      spi_din = ~spi_din;
      #40;
    end
  endtask
endmodule // spiee_host

//--- sim/spiee_tb.sv
// Testbench for the serial EEPROM block with the host model.
// Assumes spiee_props is bound to the design's top.
`timescale 1ns/1ps
module tb;
  localparam [15:0] PROG = 16'h0320;
  localparam logic [15:0] PRE [7] = '{16'h0000, 16'h0001, 16'h3FFF,
    16'h4000, 16'h5FFF, 16'h6000, 16'h7FFF};
  logic        ref_clk;
  logic        rst_b;
  logic        wp_b;
  wire         spi_clk;
  wire         spi_cs_b;
  wire         spi_din;
  wire         spi_dout_q;
  wire         spi_dout_oe_q;
  wire         pin_guard_mode_q;
  wire         rx_stb;
  wire [7:0]   rx_b;
  logic [7:0]  exp_q[$];
  logic        exp_pg[$];
  logic [7:0]  mem[int];
  logic [15:0] bnd;
  int          num_errors;
  int          compares;

  spiee_top #(.PROG_CYCLES(PROG)) i_spiee_top (
    .ref_clk(ref_clk), .rst_b(rst_b), .spi_clk(spi_clk),
    .spi_cs_b(spi_cs_b), .spi_din(spi_din), .spi_dout_q(spi_dout_q),
    .spi_dout_oe_q(spi_dout_oe_q), .wp_b(wp_b),
    .pin_guard_mode_q(pin_guard_mode_q)
  );
  spiee_host i_spiee_host (
    .spi_clk(spi_clk), .spi_cs_b(spi_cs_b), .spi_din(spi_din),
    .spi_dout(spi_dout_q), .spi_dout_oe(spi_dout_oe_q),
    .rx_stb(rx_stb), .rx_b(rx_b)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic fail(input string msg);
    num_errors++;
    $display("wrong value at %0t ns: %s", $time, msg);
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("byte %h, expected %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail($sformatf("guard mode %b, expected %b", got, exp));
  endtask

  // Oldest note against each result seen
  always @(rx_stb) begin
    if ($time > 0) begin
      if (exp_q.size() == 0) fail("unexpected output byte");
      else cmp_byte(rx_b, exp_q.pop_front());
    end
  end
  always @(pin_guard_mode_q) begin
    if (rst_b === 1'b1) begin
      if (exp_pg.size() == 0) fail("unexpected guard mode change");
      else cmp_bit(pin_guard_mode_q, exp_pg.pop_front());
    end
  end

  task automatic xfer(input logic [7:0] tx[$], input int nbits);
    i_spiee_host.frame(tx, nbits);
  endtask
  task automatic stat(input logic [7:0] e, input int n);
    repeat (n) exp_q.push_back(e);
    xfer({8'h05}, 8 + 8 * n);
  endtask
  task automatic pause;
    repeat (PROG + 16'h0014) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [15:0] a, input bit keep);
    logic [7:0] d;
    d = 8'($urandom);
    xfer({8'h06}, 8);
    xfer({8'h02, a[15:8], a[7:0], d}, 32);
    if (keep) mem[a[14:0]] = d;
    pause();
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    for (int j = 0; j < n; j++) exp_q.push_back(mem[(a + j) % 32768]);
    xfer({8'h03, a[15:8], a[7:0]}, 24 + 8 * n);
  endtask
  task automatic wsr(input logic [7:0] s, input int nbits);
    xfer({8'h06}, 8);
    xfer({8'h01, s}, nbits);
    pause();
  endtask
  task automatic final_report;
    if (exp_q.size() != 0) fail("output bytes missing");
    if (exp_pg.size() != 0) fail("guard mode changes missing");
    $display("compares %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    fail("run timed out");
    final_report();
  end

  initial begin
    num_errors = 0;
    compares = 0;
    void'($urandom(63));
    rst_b = 1'b0;
    wp_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    stat(8'h00, 1);
    xfer({8'h06, 8'h04}, 16);
    stat(8'h02, 1);
    xfer({8'h04, 8'h06}, 16);
    stat(8'h00, 1);
    xfer({8'hFF, 8'h05}, 24);
    xfer({8'h01, 8'h0C}, 16);
    pause();
    stat(8'h00, 1);
    wsr(8'h0C, 17);
    stat(8'h02, 1);
    xfer({8'h02, 8'h00, 8'h10, 8'h5A}, 31);
    xfer({8'h02, 8'h00, 8'h10, 8'h5A}, 33);
    stat(8'h02, 1);
    xfer({8'h02, 8'h80, 8'h00, 8'hA5}, 32);
    mem[0] = 8'hA5;
    xfer({8'h03, 8'h00, 8'h00}, 40);
    stat(8'h03, 3);
    pause();
    stat(8'h00, 1);
    rd(16'h8000, 1);
    for (int i = 0; i < 7; i++) wr(PRE[i], 1'b1);
    xfer({8'h06}, 8);
    xfer({8'h02, 8'h00, 8'h3F, 8'h3C, 8'hC3}, 40);
    mem[16'h003F] = 8'h3C;
    mem[0] = 8'hC3;
    pause();
    rd(16'h7FFF, 2);
    xfer({8'h06}, 8);
    xfer({8'h01, 8'h84}, 16);
    stat(8'h03, 1);
    pause();
    stat(8'h84, 1);
    for (int g = 1; g < 4; g++) begin
      bnd = (g == 1) ? 16'h6000 : (g == 2) ? 16'h4000 : 16'h0000;
      wsr({4'h0, 2'(g), 2'h0}, 16);
      stat({4'h0, 2'(g), 2'h0}, 1);
      wr(bnd, 1'b0);
      if (g < 3) wr(bnd - 16'h0001, 1'b1);
      rd((g < 3) ? bnd - 16'h0001 : bnd, 2);
    end
    exp_pg.push_back(1'b1);
    @(negedge ref_clk) wp_b = 1'b0;
    wsr(8'h8C, 16);
    wsr(8'h00, 16);
    wr(16'h0001, 1'b0);
    xfer({8'h04}, 8);
    stat(8'h8C, 1);
    rd(16'h0000, 2);
    exp_pg.push_back(1'b0);
    @(negedge ref_clk) wp_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    stat(8'h8C, 1);
    wsr(8'h80, 16);
    stat(8'h80, 1);
    exp_pg.push_back(1'b1);
    @(negedge ref_clk) wp_b = 1'b0;
    repeat (8) @(negedge ref_clk);
    exp_pg.push_back(1'b0);
    @(negedge ref_clk) wp_b = 1'b1;
    repeat (8) @(negedge ref_clk);
    final_report();
  end
endmodule // tb
